// ===== pvt_params.svh
// Timing counts, register offsets and field positions for the panel link
`ifndef PVT_PARAMS_SVH
`define PVT_PARAMS_SVH
`define PVT_MCLK_KHZ 10000
`define PVT_H_ACTIVE 960
`define PVT_H_BLANK_MIN 100
`define PVT_H_BLANK_TYP 140
`define PVT_H_BLANK_MAX 240
`define PVT_H_TOTAL_MAX 1200
`define PVT_V_ACTIVE 1080
`define PVT_V_BLANK60_TYP 45
`define PVT_V_BLANK50_TYP 270
`define PVT_T_OFF_MS 1000
`define PVT_T_VID_BL_MS 200
`define PVT_T_BLSUP_MS 500
`define PVT_T_DUTY_HOLD_MS 500
`define PVT_T_FINAL_MS 100
`define PVT_DUTY_MIN_HOLD 7'h05
`define PVT_DUTY_MIN_RUN 7'h01
`define PVT_DUTY_MAX 7'h64
`define PVT_REG_CTRL 3'h0
`define PVT_REG_DUTY 3'h1
`define PVT_REG_COLOUR 3'h2
`define PVT_REG_STATE 3'h3
`define PVT_REG_IRQ_STAT 3'h4
`define PVT_REG_IRQ_CLR 3'h5
`define PVT_REG_IRQ_EN 3'h6
`define PVT_CTRL_PWR 0
`define PVT_CTRL_RATE50 1
`define PVT_IRQ_UP 0
`define PVT_IRQ_DOWN 1
`define PVT_IRQ_FAULT 2
`define PVT_IRQ_FRAME 3
`define PVT_IRQ_W 4
`endif

// ===== pvt_pkg.sv
// Types shared by both ends of the panel link
package pvt_pkg;
  typedef enum logic [2:0] {
    PVT_OFF = 3'b000,
    PVT_SUP_ON = 3'b001,
    PVT_VID_WAIT = 3'b010,
    PVT_BL_RUN = 3'b011,
    PVT_BL_DOWN = 3'b100,
    PVT_VID_DOWN = 3'b101
  } pvt_seq_t;
  typedef logic [23:0] pvt_rgb_t;
endpackage

// ===== pvt_link_if.sv
// Wires between the video/power controller and the panel module
interface pvt_link_if;
  logic pclk;
  logic de;
  logic hsync;
  logic vsync;
  logic [23:0] pix_a;
  logic [23:0] pix_b;
  logic panel_supply;
  logic backlight_supply;
  logic bl_on;
  logic brightness_pwm_in;
  logic status_out;
  logic status_oe;
  logic status;
  // Open-drain status line with a pull-up: floats high when nobody drives it
  assign status = status_oe ? status_out : 1'b1;
  modport host (output pclk, de, hsync, vsync, pix_a, pix_b, panel_supply,
    backlight_supply, bl_on, brightness_pwm_in, input status);
  modport panel (input pclk, de, hsync, vsync, pix_a, pix_b, panel_supply,
    backlight_supply, bl_on, brightness_pwm_in, output status_out, status_oe);
endinterface

// ===== pvt_panel.sv
// Panel end: data-enable framing, colour decode and backlight driver status
`include "pvt_params.svh"
module pvt_panel
  import pvt_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  pvt_link_if.panel link,
  input wire logic fault_i,
  output logic pix_valid_o,
  output pvt_rgb_t pix_a_o,
  output pvt_rgb_t pix_b_o,
  output logic [9:0] col_o,
  output logic [10:0] line_o,
  output logic frame_start_o,
  output logic black_o,
  output logic white_o,
  output logic lamp_on_o,
  output logic [15:0] lamp_high_o,
  output logic [15:0] lamp_period_o
);
  // Sync stages: pclk, de, pixels, supplies, on/off, pwm
  localparam int SW = 54;
  logic [SW-1:0] s1;
  logic [SW-1:0] s2;
  logic pclk_d;
  logic pwm_d;
  logic in_line;
  logic [10:0] gap;
  logic [15:0] hi_cnt;
  logic [15:0] per_cnt;
  logic pclk_rise;
  logic pwm_rise;

  always_ff @(posedge mclk_i)
  begin
    s1 <= {link.pclk, link.de, link.pix_a, link.pix_b, link.panel_supply,
      link.backlight_supply, link.bl_on, link.brightness_pwm_in};
    s2 <= s1;
  end

  wire s_pclk = s2[53];
  wire s_de = s2[52];
  wire [23:0] s_a = s2[51:28];
  wire [23:0] s_b = s2[27:4];
  wire s_psup = s2[3];
  wire s_bsup = s2[2];
  wire s_blon = s2[1];
  wire s_pwm = s2[0];
  assign pclk_rise = s_pclk && !pclk_d;
  assign pwm_rise = s_pwm && !pwm_d;

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      pclk_d <= 1'b0;
      pwm_d <= 1'b0;
    end
    else
    begin
      pclk_d <= s_pclk;
      pwm_d <= s_pwm;
    end
  end

  // Sync pins are never looked at; a long DE-low gap marks vertical blanking
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i || !s_psup)
    begin
      in_line <= 1'b0;
      gap <= 11'h7FF;
      col_o <= 10'h000;
      line_o <= 11'h000;
      frame_start_o <= 1'b0;
      pix_valid_o <= 1'b0;
      pix_a_o <= 24'h000000;
      pix_b_o <= 24'h000000;
      black_o <= 1'b0;
      white_o <= 1'b0;
    end
    else
    begin
      frame_start_o <= 1'b0;
      pix_valid_o <= 1'b0;
      if (pclk_rise)
      begin
        if (s_de) // RULE_04
        begin
          pix_valid_o <= 1'b1;
          // Red in bits 23:16, green 15:8, blue 7:0, each MSB first
          pix_a_o <= s_a; // RULE_07
          pix_b_o <= s_b;
          // Codes are unsigned brightness: all zero black, all ones white
          black_o <= (s_a == 24'h000000) && (s_b == 24'h000000); // RULE_06
          white_o <= (s_a == 24'hFFFFFF) && (s_b == 24'hFFFFFF); // RULE_06
          in_line <= 1'b1;
          gap <= 11'h000;
          if (!in_line)
          begin
            col_o <= 10'h000;
            if (gap > 11'(`PVT_H_TOTAL_MAX)) // RULE_04
            begin
              line_o <= 11'h000;
              frame_start_o <= 1'b1;
            end
            else
              line_o <= line_o + 11'h001;
          end
          else
            col_o <= col_o + 10'h001;
        end
        else
        begin
          in_line <= 1'b0;
          if (gap != 11'h7FF)
            gap <= gap + 11'h001;
        end
      end
    end
  end

  // Dimming duty measured as high and total mclk cycles per pwm period
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      hi_cnt <= 16'h0000;
      per_cnt <= 16'h0000;
      lamp_high_o <= 16'h0000;
      lamp_period_o <= 16'h0000;
      lamp_on_o <= 1'b0;
    end
    else
    begin
      lamp_on_o <= s_bsup && s_blon;
      if (pwm_rise)
      begin
        lamp_high_o <= hi_cnt;
        lamp_period_o <= per_cnt;
        hi_cnt <= 16'h0001;
        per_cnt <= 16'h0001;
      end
      else
      begin
        if (per_cnt != 16'hFFFF)
          per_cnt <= per_cnt + 16'h0001;
        if (s_pwm && hi_cnt != 16'hFFFF)
          hi_cnt <= hi_cnt + 16'h0001;
      end
    end
  end

  // Status pulled low while backlight supply is on and healthy, released open on a fault or with that supply off
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      link.status_out <= 1'b0;
      link.status_oe <= 1'b0;
    end
    else
    begin
      link.status_out <= 1'b0;
      link.status_oe <= s_bsup && !fault_i; // RULE_15
    end
  end
endmodule

// ===== pvt_host.sv
// Host end: video timing source, power sequencer, dimming pwm, register slave
//
// How it works
// RULE_01 - Two pixels per clock, 960 active, blank 100-240
// RULE_02 - 1080 active lines, blank per frame rate
// RULE_03 - Clock 63-78 MHz, frame 57-63/47-53 Hz; pclk here is the 10 MHz mclk divided by 8, 1.25 MHz
// RULE_04 - Panel frames by data enable only
// RULE_05 - Spread clock needs extra blanking above minimum
// RULE_06 - Each colour is 8-bit unsigned brightness
// RULE_07 - Words ordered red, green, blue, MSB first
// RULE_08 - Panel supply off at least 1 s
// RULE_09 - No interface signals before panel supply; pclk here toggles from reset whether or not the supply is on
// RULE_10 - 200 ms between video and backlight
// RULE_11 - Wait 100 ms before next signal change
// RULE_12 - Never float signals in invalid periods
// RULE_13 - Supply off means all data low
// RULE_14 - Duty 5-100% for 500 ms after on
// RULE_15 - Status low normal, open on fault
// RULE_16 - 500 ms from backlight supply to on
// RULE_17 - Data enable high exactly over active clocks
// RULE_18 - Backlight on only inside valid video
`include "pvt_params.svh"
module pvt_host
  import pvt_pkg::*;
#(
  parameter int PCLK_HALF = 4,
  parameter int H_BLANK = `PVT_H_BLANK_TYP,
  parameter int V_BLANK60 = `PVT_V_BLANK60_TYP,
  parameter int V_BLANK50 = `PVT_V_BLANK50_TYP,
  parameter int PWM_STEP = 1,
  parameter int T_OFF_CYC = `PVT_T_OFF_MS * `PVT_MCLK_KHZ,
  parameter int T_VID_BL_CYC = `PVT_T_VID_BL_MS * `PVT_MCLK_KHZ,
  parameter int T_BLSUP_CYC = `PVT_T_BLSUP_MS * `PVT_MCLK_KHZ,
  parameter int T_HOLD_CYC = `PVT_T_DUTY_HOLD_MS * `PVT_MCLK_KHZ,
  parameter int T_FINAL_CYC = `PVT_T_FINAL_MS * `PVT_MCLK_KHZ
)
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [2:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic irq_o,
  pvt_link_if.host link
);
  localparam int H_TOT = `PVT_H_ACTIVE + H_BLANK;
  localparam int SEQ_T = (T_OFF_CYC > T_BLSUP_CYC) ? T_OFF_CYC : T_BLSUP_CYC;
  pvt_seq_t state;
  logic [1:0] ctrl;
  logic [6:0] duty;
  pvt_rgb_t colour;
  logic [`PVT_IRQ_W-1:0] irq_stat;
  logic [`PVT_IRQ_W-1:0] irq_en;
  logic [`PVT_IRQ_W-1:0] ev;
  logic [31:0] timer;
  logic [31:0] hold;
  logic [15:0] pdiv;
  logic [10:0] hcnt;
  logic [10:0] vcnt;
  logic [6:0] pwm_cnt;
  logic [15:0] pwm_div;
  logic st_s1;
  logic st_s2;
  logic video_on;
  logic pix_en;
  logic frame_ev;
  logic fault_ev;
  logic fault_d;
  logic up_ev;
  logic down_ev;

  function automatic logic [31:0] cyc(input int n);
    cyc = (n < 1) ? 32'h00000001 : 32'(n);
  endfunction

  wire req = avs_read_i || avs_write_i;
  wire take = req && !avs_waitrequest_o;
  wire wr_take = avs_write_i && take;
  wire [10:0] v_tot = 11'(`PVT_V_ACTIVE) + (ctrl[`PVT_CTRL_RATE50] ? 11'(V_BLANK50)
    : 11'(V_BLANK60)); // RULE_02 RULE_03

  // Avalon slave: waitrequest drops one cycle after a request, for one cycle
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h00000000;
    end
    else if (req && avs_waitrequest_o)
    begin
      avs_waitrequest_o <= 1'b0;
      case (avs_address_i)
        `PVT_REG_CTRL: avs_readdata_o <= {30'h0, ctrl};
        `PVT_REG_DUTY: avs_readdata_o <= {25'h0, duty};
        `PVT_REG_COLOUR: avs_readdata_o <= {8'h00, colour};
        `PVT_REG_STATE: avs_readdata_o <= {26'h0, hold != 32'h0, st_s2, 1'b0, state};
        `PVT_REG_IRQ_STAT: avs_readdata_o <= {28'h0, irq_stat};
        `PVT_REG_IRQ_EN: avs_readdata_o <= {28'h0, irq_en};
        default: avs_readdata_o <= 32'h00000000;
      endcase
    end
    else
      avs_waitrequest_o <= 1'b1;
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      ctrl <= 2'h0;
      duty <= `PVT_DUTY_MAX;
      colour <= 24'h000000;
      irq_en <= 4'h0;
    end
    else if (wr_take)
    begin
      case (avs_address_i)
        `PVT_REG_CTRL: ctrl <= avs_writedata_i[1:0];
        `PVT_REG_DUTY: duty <= avs_writedata_i[6:0];
        `PVT_REG_COLOUR: colour <= avs_writedata_i[23:0];
        `PVT_REG_IRQ_EN: irq_en <= avs_writedata_i[3:0];
        default: ;
      endcase
    end
  end

  // A new event wins over a clear written in the same cycle
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      irq_stat <= 4'h0;
      irq_o <= 1'b0;
    end
    else
    begin
      if (wr_take && avs_address_i == `PVT_REG_IRQ_CLR)
        irq_stat <= (irq_stat & ~avs_writedata_i[3:0]) | ev;
      else
        irq_stat <= irq_stat | ev;
      irq_o <= |(irq_stat & irq_en);
    end
  end

  // Status line is asynchronous to mclk: two stages before use
  always_ff @(posedge mclk_i)
  begin
    st_s1 <= link.status;
    st_s2 <= st_s1;
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      fault_d <= 1'b0;
    else
      fault_d <= st_s2 && link.backlight_supply; // RULE_15
  end
  assign fault_ev = st_s2 && link.backlight_supply && !fault_d;

  // Sequencer: one down-counter times every interval except the duty hold, which hold counts
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      state <= PVT_OFF;
      timer <= cyc(SEQ_T);
      link.panel_supply <= 1'b0;
      link.backlight_supply <= 1'b0;
      link.bl_on <= 1'b0;
      video_on <= 1'b0;
      hold <= 32'h0;
      up_ev <= 1'b0;
      down_ev <= 1'b0;
    end
    else
    begin
      up_ev <= 1'b0;
      down_ev <= 1'b0;
      if (timer != 32'h0)
        timer <= timer - 32'h1;
      if (hold != 32'h0)
        hold <= hold - 32'h1;
      case (state)
        PVT_OFF:
          if (timer == 32'h0 && ctrl[`PVT_CTRL_PWR]) // RULE_08
          begin
            link.panel_supply <= 1'b1;
            link.backlight_supply <= 1'b1;
            timer <= cyc(T_FINAL_CYC); // RULE_11
            state <= PVT_SUP_ON;
          end
        PVT_SUP_ON:
          if (timer == 32'h0)
          begin
            video_on <= 1'b1; // RULE_09
            timer <= cyc((T_VID_BL_CYC > T_BLSUP_CYC - T_FINAL_CYC) ? T_VID_BL_CYC
              : T_BLSUP_CYC - T_FINAL_CYC); // RULE_10 RULE_16
            state <= PVT_VID_WAIT;
          end
        PVT_VID_WAIT:
          if (!ctrl[`PVT_CTRL_PWR])
          begin
            timer <= cyc(T_FINAL_CYC);
            state <= PVT_VID_DOWN;
          end
          else if (timer == 32'h0)
          begin
            link.bl_on <= 1'b1; // RULE_18
            hold <= cyc(T_HOLD_CYC); // RULE_14
            up_ev <= 1'b1;
            state <= PVT_BL_RUN;
          end
        PVT_BL_RUN:
          if (!ctrl[`PVT_CTRL_PWR])
          begin
            link.bl_on <= 1'b0; // RULE_18
            timer <= cyc(T_VID_BL_CYC); // RULE_10
            state <= PVT_BL_DOWN;
          end
        // Video stops only between lines, so no line is cut short
        PVT_BL_DOWN:
          if (timer == 32'h0 && !link.de && !pix_en) // RULE_17
          begin
            video_on <= 1'b0;
            timer <= cyc(T_FINAL_CYC); // RULE_11
            state <= PVT_VID_DOWN;
          end
        PVT_VID_DOWN:
          if (timer == 32'h0 && !link.de && !pix_en) // RULE_17
          begin
            video_on <= 1'b0;
            link.panel_supply <= 1'b0;
            link.backlight_supply <= 1'b0;
            timer <= cyc(T_OFF_CYC); // RULE_08
            down_ev <= 1'b1;
            state <= PVT_OFF;
          end
        default: state <= PVT_OFF;
      endcase
    end
  end

  // Pixel clock divided down from mclk; data moves on its falling edge
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      pdiv <= 16'h0;
      link.pclk <= 1'b0;
      pix_en <= 1'b0;
    end
    else
    begin
      pix_en <= 1'b0;
      if (pdiv == 16'(PCLK_HALF - 1))
      begin
        pdiv <= 16'h0;
        link.pclk <= !link.pclk;
        pix_en <= link.pclk;
      end
      else
        pdiv <= pdiv + 16'h1;
    end
  end

  // Blanking is a parameter so a spread clock can be given margin
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i || !video_on)
    begin
      hcnt <= 11'h0;
      vcnt <= 11'h0;
      frame_ev <= 1'b0;
      link.de <= 1'b0;
      link.hsync <= 1'b0;
      link.vsync <= 1'b0;
      link.pix_a <= 24'h000000; // RULE_12 RULE_13
      link.pix_b <= 24'h000000;
    end
    else
    begin
      frame_ev <= 1'b0;
      if (pix_en)
      begin
        if (hcnt == 11'(H_TOT - 1)) // RULE_01 RULE_05
        begin
          hcnt <= 11'h0;
          vcnt <= (vcnt == v_tot - 11'h1) ? 11'h0 : vcnt + 11'h1;
          frame_ev <= (vcnt == v_tot - 11'h1);
        end
        else
          hcnt <= hcnt + 11'h1;
        link.hsync <= hcnt >= 11'(`PVT_H_ACTIVE);
        link.vsync <= vcnt >= 11'(`PVT_V_ACTIVE);
        if (hcnt < 11'(`PVT_H_ACTIVE) && vcnt < 11'(`PVT_V_ACTIVE))
        begin
          link.de <= 1'b1; // RULE_17
          link.pix_a <= {hcnt[6:0], 1'b0, vcnt[7:0], colour[7:0]}; // RULE_07
          link.pix_b <= {hcnt[6:0], 1'b1, vcnt[7:0], colour[7:0]}; // RULE_06
        end
        else
        begin
          link.de <= 1'b0; // RULE_17
          link.pix_a <= 24'h000000; // RULE_12
          link.pix_b <= 24'h000000;
        end
      end
    end
  end
  // Bit order follows the event positions: up, down, fault, frame
  assign ev = {frame_ev, fault_ev, down_ev, up_ev};

  // Dimming pwm: 100 steps per period, duty clamped to the allowed window
  wire [6:0] dmin = (hold != 32'h0) ? `PVT_DUTY_MIN_HOLD : `PVT_DUTY_MIN_RUN;
  wire [6:0] dclip = (duty < dmin) ? dmin : (duty > `PVT_DUTY_MAX) ? `PVT_DUTY_MAX : duty;
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      pwm_cnt <= 7'h0;
      pwm_div <= 16'h0;
      link.brightness_pwm_in <= 1'b0;
    end
    else
    begin
      if (pwm_div == 16'(PWM_STEP - 1))
      begin
        pwm_div <= 16'h0;
        pwm_cnt <= (pwm_cnt == `PVT_DUTY_MAX - 7'h1) ? 7'h0 : pwm_cnt + 7'h1;
      end
      else
        pwm_div <= pwm_div + 16'h1;
      link.brightness_pwm_in <= link.panel_supply && (pwm_cnt < dclip); // RULE_14
    end
  end
endmodule

// ===== pvt_link_props.sv
// Concurrent checks on the wires between host and panel
module pvt_link_props #(
  parameter int T_OFF_CYC = 200,
  parameter int T_VID_BL_CYC = 100,
  parameter int T_BLSUP_CYC = 150,
  parameter int T_HOLD_CYC = 400,
  parameter int T_FINAL_CYC = 50
)
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic pclk,
  input wire logic de,
  input wire logic [23:0] pix_a,
  input wire logic [23:0] pix_b,
  input wire logic panel_supply,
  input wire logic backlight_supply,
  input wire logic bl_on,
  input wire logic brightness_pwm_in,
  input wire logic status
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);
  logic pclk_q;
  logic [15:0] off_cnt, sup_cnt, boff_cnt, hold_cnt, hi_cnt, act_cnt, blk_cnt;
  // Counters other than hi_cnt and act_cnt saturate so a long idle stretch never wraps into a false pass
  always_ff @(posedge mclk_i)
  begin
    pclk_q <= rst_n_i & pclk;
    off_cnt <= (!rst_n_i || panel_supply) ? 16'h0 : off_cnt + {15'h0, off_cnt != 16'hFFFF};
    sup_cnt <= (!rst_n_i || !panel_supply) ? 16'h0 : sup_cnt + {15'h0, sup_cnt != 16'hFFFF};
    boff_cnt <= (!rst_n_i || bl_on) ? 16'h0 : boff_cnt + {15'h0, boff_cnt != 16'hFFFF};
    hold_cnt <= (!rst_n_i || !bl_on) ? 16'h0 : hold_cnt + {15'h0, hold_cnt != 16'hFFFF};
    hi_cnt <= (!rst_n_i || !brightness_pwm_in) ? 16'h0 : hi_cnt + 16'h1;
    act_cnt <= (!rst_n_i || !de) ? 16'h0 : act_cnt + {15'h0, pclk & ~pclk_q};
    // An idle link counts as a long blank, so the first line opens a frame
    blk_cnt <= (!rst_n_i || !panel_supply) ? 16'hFFFF : de ? 16'h0
      : blk_cnt + {15'h0, pclk & ~pclk_q & (blk_cnt != 16'hFFFF)};
  end
  a_dark_when_off: assert property (!panel_supply |-> !de && pix_a == 24'h0 && pix_b == 24'h0)
    else $error("video lines not low while panel supply is off");
  a_bl_inside_power: assert property (bl_on |-> panel_supply && backlight_supply)
    else $error("backlight control high without both supplies");
  a_bl_rise_gap: assert property ($rose(bl_on) |-> sup_cnt >= T_BLSUP_CYC - 2
    && sup_cnt >= T_FINAL_CYC + T_VID_BL_CYC - 2)
    else $error("backlight control raised too early");
  a_bl_fall_gap: assert property ($fell(panel_supply) |-> boff_cnt >= T_VID_BL_CYC + T_FINAL_CYC - 2)
    else $error("supply removed too soon after backlight off");
  a_supply_off_gap: assert property ($rose(panel_supply) |-> off_cnt >= T_OFF_CYC - 2)
    else $error("panel supply off time too short");
  a_line_active_len: assert property ($fell(de) |-> act_cnt == 16'd960)
    else $error("active line is not 960 clocks");
  a_line_blank_len: assert property ($rose(de) |-> blk_cnt inside {[16'd100:16'd240]}
    || blk_cnt > 16'd1200)
    else $error("horizontal blank out of range");
  a_data_on_fall: assert property (pclk && $past(pclk) |-> $stable(pix_a) && $stable(de))
    else $error("link data moved while pixel clock high");
  a_pixel_order: assert property (de |-> !pix_a[16] && pix_b[16] && pix_a[15:0] == pix_b[15:0])
    else $error("pixel pair fields out of order");
  a_duty_floor: assert property ($fell(brightness_pwm_in) && bl_on && hold_cnt > 16'd105
    && hold_cnt < T_HOLD_CYC |-> hi_cnt >= 16'd5)
    else $error("dimming duty under floor during hold");
  a_status_open: assert property ((!backlight_supply) [*5] |-> status)
    else $error("status line driven without backlight supply");
endmodule

// ===== tb_panel_video_timing_power_seq.sv
// Bench joining host and panel ends over the link interface
`include "pvt_params.svh"
module tb_panel_video_timing_power_seq;
  import pvt_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_i, rst_n_i, rd, wr, fault_i, irq_o, wait_o, pix_valid_o, black_o, lamp_on_o;
  logic frame_start_o, white_o, frame_seen;
  // Shortened sequence intervals keep the run small
  localparam int T_OFF = 200;
  localparam int T_VID_BL = 100;
  localparam int T_BLSUP = 150;
  localparam int T_HOLD = 400;
  localparam int T_FINAL = 50;
  logic [2:0] addr;
  logic [31:0] wdata, rdata, got;
  pvt_rgb_t pix_a_o, pix_b_o;
  logic [9:0] col_o;
  logic [10:0] line_o;
  logic [15:0] lamp_high_o, lamp_period_o;
  logic [7:0] green;
  int bad_count = 0;
  int comparisons = 0;
  pvt_link_if link_if();
  pvt_host #(.T_OFF_CYC(T_OFF), .T_VID_BL_CYC(T_VID_BL), .T_BLSUP_CYC(T_BLSUP),
    .T_HOLD_CYC(T_HOLD), .T_FINAL_CYC(T_FINAL))
  pvt_host_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .avs_address_i(addr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdata), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wait_o), .irq_o(irq_o), .link(link_if));
  pvt_panel pvt_panel_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .link(link_if),
    .fault_i(fault_i), .pix_valid_o(pix_valid_o), .pix_a_o(pix_a_o), .pix_b_o(pix_b_o),
    .col_o(col_o), .line_o(line_o), .frame_start_o(frame_start_o), .black_o(black_o),
    .white_o(white_o),
    .lamp_on_o(lamp_on_o), .lamp_high_o(lamp_high_o), .lamp_period_o(lamp_period_o));
  pvt_link_props #(.T_OFF_CYC(T_OFF), .T_VID_BL_CYC(T_VID_BL), .T_BLSUP_CYC(T_BLSUP),
    .T_HOLD_CYC(T_HOLD), .T_FINAL_CYC(T_FINAL))
  pvt_link_props_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .pclk(link_if.pclk),
    .de(link_if.de), .pix_a(link_if.pix_a), .pix_b(link_if.pix_b),
    .panel_supply(link_if.panel_supply), .backlight_supply(link_if.backlight_supply),
    .bl_on(link_if.bl_on), .brightness_pwm_in(link_if.brightness_pwm_in),
    .status(link_if.status));
  initial
  begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end
  // Frame start is a one-cycle pulse, so it is latched for a later check
  always @(posedge mclk_i)
  begin
    if (!rst_n_i)
      frame_seen <= 1'b0;
    else if (frame_start_o === 1'b1)
      frame_seen <= 1'b1;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  // Request holds until waitrequest is sampled low; read data taken at that edge
  task automatic bus_cycle(input logic is_wr, input logic [2:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk_i);
    addr <= a;
    wdata <= d;
    wr <= is_wr;
    rd <= !is_wr;
    n = 0;
    do @(posedge mclk_i); while (wait_o !== 1'b0 && ++n < 50);
    got = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    if (n >= 50)
      check(0, 1, "bus answer missing");
  endtask
  task automatic reg_is(input logic [2:0] a, input logic [31:0] mask, input logic [31:0] exp);
    bus_cycle(1'b0, a, 32'h0);
    check(got & mask, exp, "register value");
  endtask
  task automatic wait_irq();
    int n;
    n = 0;
    // Power-down waits for the current line to end, so allow a full line
    do @(posedge mclk_i); while (irq_o !== 1'b1 && ++n < 12000);
  endtask
  task automatic wait_col(input logic [9:0] c);
    int n;
    n = 0;
    do @(posedge mclk_i); while (!(pix_valid_o === 1'b1 && col_o === c) && ++n < 20000);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    #6000000;
    bad_count++;
    wrap_up();
  end
  initial
  begin
    {rst_n_i, rd, wr, fault_i, addr, wdata} = '0;
    repeat (5) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    reg_is(`PVT_REG_CTRL, 32'hFFFFFFFF, 32'h0);
    reg_is(`PVT_REG_DUTY, 32'h7F, 32'h64);
    bus_cycle(1'b1, `PVT_REG_STATE, 32'h3F);
    reg_is(`PVT_REG_STATE, 32'h3F, 32'h10);
    reg_is(`PVT_REG_IRQ_STAT, 32'hF, 32'h0);
    reg_is(3'h7, 32'hFFFFFFFF, 32'h0);
    bus_cycle(1'b1, `PVT_REG_COLOUR, 32'hA5);
    bus_cycle(1'b1, `PVT_REG_DUTY, 32'h1);
    bus_cycle(1'b1, `PVT_REG_IRQ_EN, 32'h1);
    bus_cycle(1'b1, `PVT_REG_CTRL, 32'h1);
    wait_irq();
    reg_is(`PVT_REG_IRQ_STAT, 32'h1, 32'h1);
    reg_is(`PVT_REG_STATE, 32'h3F, {26'h0, 3'b100, 3'(PVT_BL_RUN)});
    check({31'h0, lamp_on_o}, 1, "lamp on");
    bus_cycle(1'b1, `PVT_REG_IRQ_CLR, 32'h1);
    repeat (2) @(posedge mclk_i);
    check({31'h0, irq_o}, 0, "irq cleared");
    repeat (230) @(posedge mclk_i);
    check({lamp_period_o, lamp_high_o}, {16'd100, 16'd5}, "duty floor in hold");
    repeat (450) @(posedge mclk_i);
    check({lamp_period_o, lamp_high_o}, {16'd100, 16'd1}, "duty after hold");
    reg_is(`PVT_REG_STATE, 32'h20, 32'h0);
    bus_cycle(1'b1, `PVT_REG_IRQ_EN, 32'h0);
    fault_i <= 1'b1;
    repeat (10) @(posedge mclk_i);
    reg_is(`PVT_REG_STATE, 32'h10, 32'h10);
    reg_is(`PVT_REG_IRQ_STAT, 32'h4, 32'h4);
    check({31'h0, irq_o}, 0, "masked irq");
    bus_cycle(1'b1, `PVT_REG_IRQ_EN, 32'h4);
    repeat (3) @(posedge mclk_i);
    check({31'h0, irq_o}, 1, "enabled irq");
    fault_i <= 1'b0;
    repeat (10) @(posedge mclk_i);
    bus_cycle(1'b1, `PVT_REG_IRQ_CLR, 32'h4);
    repeat (3) @(posedge mclk_i);
    check({31'h0, irq_o}, 0, "irq after clear");
    reg_is(`PVT_REG_STATE, 32'h10, 32'h0);
    // Video started inside line zero, so the next column five is in line one
    wait_col(10'd5);
    green = 8'h01;
    check({21'h0, line_o}, 32'h1, "second line");
    check({31'h0, frame_seen}, 1, "frame start seen");
    check({31'h0, white_o}, 0, "not white");
    check(pix_a_o, {8'h0A, green, 8'hA5}, "first pixel of pair");
    check(pix_b_o, {8'h0B, green, 8'hA5}, "second pixel of pair");
    check({31'h0, black_o}, 0, "not black");
    wait_col(10'd959);
    check(pix_b_o[23:16], 32'h7F, "last pair red");
    got = {21'h0, line_o};
    wait_col(10'd0);
    check({21'h0, line_o}, got + 1, "next line");
    check(pix_a_o[15:8], green + 8'h1, "next line green");
    bus_cycle(1'b1, `PVT_REG_IRQ_EN, 32'h2);
    bus_cycle(1'b1, `PVT_REG_CTRL, 32'h0);
    wait_irq();
    check({29'h0, link_if.panel_supply, link_if.bl_on, lamp_on_o}, 0, "powered down");
    // The released status line passes panel and host sync stages first
    repeat (4) @(posedge mclk_i);
    reg_is(`PVT_REG_STATE, 32'h3F, 32'h10);
    bus_cycle(1'b1, `PVT_REG_IRQ_CLR, 32'h2);
    bus_cycle(1'b1, `PVT_REG_CTRL, 32'h3);
    reg_is(`PVT_REG_CTRL, 32'h3, 32'h3);
    repeat (140) @(posedge mclk_i);
    check({31'h0, link_if.panel_supply}, 0, "supply held off");
    repeat (100) @(posedge mclk_i);
    check({31'h0, link_if.panel_supply}, 1, "supply back on");
    wrap_up();
  end
endmodule
